// file: hw/mmx_defines.svh
// Constants for the move and multiply execution datapath
// Operation
// - Load immediate into accumulator, flags untouched
// - Store accumulator to addressed byte, flags untouched
// - Store operand reaches all 256 bank bytes
// - Access bit picks access or selected bank
// - Extended set, access clear, f<=95 indexed
// - Multiply accumulator by immediate
// - Unsigned 16-bit product, high byte high
// - Immediate multiply keeps accumulator and flags
// - Memory multiply keeps both operands unchanged
// - Memory multiply flags nothing, no zero detect
`ifndef MMX_DEFINES_SVH
`define MMX_DEFINES_SVH
`define MMX_OP_LOAD_IMM 8'h0E
`define MMX_OP_MUL_IMM 8'h0D
`define MMX_OP7_STORE 7'h37
`define MMX_OP7_MUL_REG 7'h01
`define MMX_INDEX_LIMIT 8'h5F
`define MMX_ACCESS_BANK 4'h0
`define MMX_ACC_RESET 8'h00
`define MMX_PROD_RESET 16'h0000
`define MMX_PHASE_READ 2'h1
`define MMX_PHASE_WRITE 2'h3
`endif

// file: hw/mmx_pkg.sv
// Types for the move and multiply execution datapath
package mmx_pkg;
  typedef enum logic [1:0] {
    MMX_Q1 = 2'b00,
    MMX_Q2 = 2'b01,
    MMX_Q3 = 2'b10,
    MMX_Q4 = 2'b11
  } mmx_phase_t;
  typedef enum logic [2:0] {
    MMX_OP_NONE = 3'b000,
    MMX_OP_LDI = 3'b001,
    MMX_OP_STO = 3'b010,
    MMX_OP_MLI = 3'b011,
    MMX_OP_MLR = 3'b100
  } mmx_op_t;
endpackage : mmx_pkg

// file: hw/mmx_multiplier.sv
// Unsigned combinational multiplier
`timescale 1ns/100ps
`default_nettype none
module mmx_multiplier #(
  parameter int WIDTH = 8
) (
  input wire logic [WIDTH-1:0] a,
  input wire logic [WIDTH-1:0] b,
  output logic [2*WIDTH-1:0] product
);
  initial
  begin
    if (WIDTH < 1)
      $error("mmx_multiplier: WIDTH must be positive");
  end
  // Unsigned, full width, no overflow possible
  assign product = {{WIDTH{1'b0}}, a} * {{WIDTH{1'b0}}, b};
endmodule : mmx_multiplier
`default_nettype wire

// file: hw/mmx_exec.sv
// Move and multiply execution datapath top
`timescale 1ns/100ps
`default_nettype none
`include "mmx_defines.svh"
module mmx_exec
  import mmx_pkg::*;
#(
  parameter int BANK_BITS = 4
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic instr_valid,
  input wire logic [15:0] instr_word,
  input wire logic extended_set_en,
  input wire logic [BANK_BITS-1:0] bank_select_reg,
  input wire logic [7:0] mem_rdata,
  output logic [BANK_BITS+7:0] mem_addr,
  output logic mem_rd,
  output logic mem_wr,
  output logic [7:0] mem_wdata,
  output logic indexed_mode,
  output logic [7:0] acc,
  output logic [7:0] product_high,
  output logic [7:0] product_low,
  output logic flags_write,
  output logic busy
);
  initial
  begin
    if (BANK_BITS < 1 || BANK_BITS > 8)
      $error("mmx_exec: BANK_BITS out of range");
  end

  typedef struct packed {
    mmx_phase_t phase;
    mmx_op_t op;
    logic [7:0] operand;
    logic [7:0] data;
    logic [15:0] product;
    logic [15:0] prod;
    logic [7:0] acc;
    logic [BANK_BITS+7:0] addr;
    logic rd;
    logic wr;
    logic [7:0] wdata;
    logic indexed;
    logic flags;
    logic busy;
  } mmx_state_t;

  localparam mmx_state_t STATE_RESET = '{
    phase: MMX_Q1,
    op: MMX_OP_NONE,
    operand: 8'h00,
    data: 8'h00,
    product: `MMX_PROD_RESET,
    prod: `MMX_PROD_RESET,
    acc: `MMX_ACC_RESET,
    addr: '0,
    rd: 1'b0,
    wr: 1'b0,
    wdata: 8'h00,
    indexed: 1'b0,
    flags: 1'b0,
    busy: 1'b0
  };

  mmx_state_t state_reg;
  mmx_state_t state_next;
  logic [15:0] mult_out;
  logic [7:0] op_hi;
  logic access_bit;
  mmx_op_t decoded_op;
  logic reg_operand;
  logic [BANK_BITS+7:0] decoded_addr;
  logic decoded_indexed;

  assign op_hi = instr_word[15:8];
  assign access_bit = instr_word[8];

  mmx_multiplier #(
    .WIDTH(8)
  ) u_mult (
    .a(state_reg.acc),
    .b(state_reg.data),
    .product(mult_out)
  );

  // Opcode decode of the presented word
  always_comb
  begin
    decoded_op = MMX_OP_NONE;
    if (op_hi == `MMX_OP_LOAD_IMM)
    begin
      decoded_op = MMX_OP_LDI;
    end
    else if (op_hi == `MMX_OP_MUL_IMM)
    begin
      decoded_op = MMX_OP_MLI;
    end
    else if (op_hi[7:1] == `MMX_OP7_STORE)
    begin
      decoded_op = MMX_OP_STO;
    end
    else if (op_hi[7:1] == `MMX_OP7_MUL_REG)
    begin
      decoded_op = MMX_OP_MLR;
    end
  end

  // Register operand address and indexed report
  always_comb
  begin
    reg_operand = (decoded_op == MMX_OP_STO) || (decoded_op == MMX_OP_MLR);
    if (access_bit)
    begin
      decoded_addr = {bank_select_reg, instr_word[7:0]};
    end
    else
    begin
      decoded_addr = {{BANK_BITS{1'b0}}, instr_word[7:0]};
    end
    decoded_indexed = !access_bit && extended_set_en
      && (instr_word[7:0] <= `MMX_INDEX_LIMIT);
  end

  always_comb
  begin
    state_next = state_reg;
    state_next.rd = 1'b0;
    state_next.wr = 1'b0;
    state_next.flags = 1'b0;
    unique case (state_reg.phase)
      MMX_Q1:
      begin
        // Decode one word instruction
        state_next.op = MMX_OP_NONE;
        state_next.operand = instr_word[7:0];
        state_next.indexed = 1'b0;
        state_next.busy = 1'b0;
        if (instr_valid)
        begin
          state_next.busy = 1'b1;
          state_next.phase = MMX_Q2;
          state_next.op = decoded_op;
          if (reg_operand)
          begin
            // Full 8-bit offset in chosen bank
            state_next.addr = decoded_addr;
            state_next.indexed = decoded_indexed;
            state_next.rd = (decoded_op == MMX_OP_MLR);
          end
        end
      end
      MMX_Q2:
      begin
        // Operand read phase
        if (state_reg.op == MMX_OP_MLR)
        begin
          state_next.data = mem_rdata;
        end
        else
        begin
          state_next.data = state_reg.operand;
        end
        state_next.phase = MMX_Q3;
      end
      MMX_Q3:
      begin
        // Process phase, product settles here
        state_next.product = mult_out;
        state_next.wdata = state_reg.acc;
        state_next.wr = (state_reg.op == MMX_OP_STO);
        state_next.phase = MMX_Q4;
      end
      MMX_Q4:
      begin
        // Destination write phase
        unique case (state_reg.op)
          MMX_OP_LDI:
          begin
            state_next.acc = state_reg.data;
          end
          MMX_OP_MLI, MMX_OP_MLR:
          begin
            state_next.prod = state_reg.product;
          end
          MMX_OP_NONE, MMX_OP_STO:
          begin
            state_next.prod = state_reg.prod;
          end
          default:
          begin
            state_next.op = MMX_OP_NONE;
          end
        endcase
        state_next.busy = 1'b0;
        state_next.phase = MMX_Q1;
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      state_reg <= STATE_RESET;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign mem_addr = state_reg.addr;
  assign mem_rd = state_reg.rd;
  assign mem_wr = state_reg.wr;
  assign mem_wdata = state_reg.wdata;
  assign indexed_mode = state_reg.indexed;
  assign acc = state_reg.acc;
  assign product_high = state_reg.prod[15:8];
  assign product_low = state_reg.prod[7:0];
  assign flags_write = state_reg.flags;
  assign busy = state_reg.busy;
endmodule : mmx_exec
`default_nettype wire

// file: verif/mmx_mem_model.sv
// Banked data memory partner for the datapath
`timescale 1ns/100ps
`default_nettype none
module mmx_mem_model (
  input wire logic core_clk,
  input wire logic [11:0] mem_addr,
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic [7:0] mem_wdata,
  output logic [7:0] mem_rdata
);
  logic [7:0] m [4096];
  always_ff @(posedge core_clk)
    if (mem_wr)
      m[mem_addr] <= mem_wdata;
  // Released bus shows inverted byte
  assign mem_rdata = mem_rd ? m[mem_addr] : ~m[mem_addr];
endmodule : mmx_mem_model
`default_nettype wire

// file: verif/mmx_exec_chk.sv
// Port checker for the move and multiply datapath
`timescale 1ns/100ps
`default_nettype none
module mmx_exec_chk #(
  parameter int BANK_BITS = 4
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic instr_valid,
  input wire logic extended_set_en,
  input wire logic [15:0] instr_word,
  input wire logic [BANK_BITS-1:0] bank_select_reg,
  input wire logic [7:0] mem_rdata,
  input wire logic [7:0] mem_wdata,
  input wire logic [7:0] acc,
  input wire logic [7:0] product_high,
  input wire logic [7:0] product_low,
  input wire logic [BANK_BITS+7:0] mem_addr,
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic indexed_mode,
  input wire logic flags_write,
  input wire logic busy
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  flags_quiet_a: assert property (flags_write == 1'b0) else $error("flags");
  busy_len_a: assert property ($rose(busy) |-> busy[*3] ##1 !busy) else $error("len");
  rd_phase_a: assert property (mem_rd |-> $rose(busy)) else $error("rd");
  store_data_a: assert property (mem_wr |-> mem_wdata == acc ##1 !busy) else $error("wr");
  addr_sel_a: assert property ($rose(busy)
    && (($past(instr_word[15:9]) == 7'h37) || ($past(instr_word[15:9]) == 7'h01))
    |-> mem_addr[7:0] == $past(instr_word[7:0])
    && mem_addr[BANK_BITS+7:8] == ($past(instr_word[8]) ? $past(bank_select_reg) : '0))
    else $error("addr");
  index_mode_a: assert property ($rose(busy)
    && (($past(instr_word[15:9]) == 7'h37) || ($past(instr_word[15:9]) == 7'h01))
    |-> indexed_mode == (!$past(instr_word[8])
    && $past(extended_set_en) && $past(instr_word[7:0]) <= 8'h5F)) else $error("idx");
  load_acc_a: assert property ($rose(busy) && $past(instr_word[15:8]) == 8'h0E
    |-> ##3 acc == $past(instr_word[7:0], 4)) else $error("load");
  mul_imm_a: assert property ($rose(busy)
    && $past(instr_word[15:8]) == 8'h0D |-> ##3
    {product_high, product_low} == acc * $past(instr_word[7:0], 4) && $stable(acc))
    else $error("mli");
  mul_reg_a: assert property ($rose(busy)
    && $past(instr_word[15:9]) == 7'h01 |-> ##3
    {product_high, product_low} == acc * $past(mem_rdata, 3)) else $error("mlr");
endmodule : mmx_exec_chk
bind mmx_exec mmx_exec_chk #(.BANK_BITS(BANK_BITS)) chk_i (.*);
`default_nettype wire

// file: verif/testbench.sv
// Self-checking bench for the move and multiply datapath
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic core_clk = 0, reset = 1, instr_valid = 0, extended_set_en = 0;
  logic [15:0] instr_word = 16'h0000;
  logic [3:0] bank_select_reg = 4'h0;
  logic [7:0] mem_rdata, mem_wdata, acc, product_high, product_low;
  logic [11:0] mem_addr;
  logic mem_rd, mem_wr, indexed_mode, flags_write, busy;
  int failures = 0, checks = 0;
  always #20 core_clk = ~core_clk;
  mmx_exec DUT (.core_clk, .reset, .instr_valid, .instr_word, .extended_set_en,
    .bank_select_reg, .mem_rdata, .mem_addr, .mem_rd, .mem_wr, .mem_wdata,
    .indexed_mode, .acc, .product_high, .product_low, .flags_write, .busy);
  mmx_mem_model mem (.core_clk, .mem_addr, .mem_rd, .mem_wr, .mem_wdata, .mem_rdata);
  task automatic end_of_test;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (e !== g)
    begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic run(input logic [15:0] w);
    int i;
    @(posedge core_clk) instr_valid <= 1'b1;
    instr_word <= w;
    @(posedge core_clk) instr_valid <= 1'b0;
    #1;
    for (i = 0; i < 9 && busy !== 1'b0; i++)
      @(posedge core_clk) #1;
    if (i == 9)
    begin
      failures++;
      end_of_test();
    end
  endtask : run
  task automatic load_scn;
    run(16'h0E5A);
    chk("acc", 16'h005A, {8'h00, acc});
  endtask : load_scn
  task automatic store_scn;
    run(16'h6EFF);
    chk("bank0", 16'h005A, {8'h00, mem.m[12'h0FF]});
    @(posedge core_clk) bank_select_reg <= 4'h5;
    run(16'h6F00);
    chk("bank5", 16'h005A, {8'h00, mem.m[12'h500]});
  endtask : store_scn
  task automatic mulimm_scn;
    run(16'h0EE2);
    run(16'h0DC4);
    chk("prod", 16'hAD08, {product_high, product_low});
    chk("acc", 16'h00E2, {8'h00, acc});
    run(16'h0EFF);
    run(16'h0DFF);
    chk("prodmax", 16'hFE01, {product_high, product_low});
    run(16'hFFFF);
    chk("noop", 16'hFE01, {product_high, product_low});
  endtask : mulimm_scn
  task automatic mulreg_scn;
    run(16'h0EB5);
    run(16'h6FB5);
    run(16'h0EC4);
    run(16'h03B5);
    chk("prod", 16'h8A94, {product_high, product_low});
    chk("src", 16'h00B5, {8'h00, mem.m[12'h5B5]});
    chk("acc", 16'h00C4, {8'h00, acc});
    chk("flags", 16'h0000, {15'h0000, flags_write});
    @(posedge core_clk) extended_set_en <= 1'b1;
    run(16'h6E5F);
    chk("idxst", 16'h0001, {15'h0000, indexed_mode});
    run(16'h6E60);
    run(16'h025F);
    chk("idx5f", 16'h0001, {15'h0000, indexed_mode});
    chk("prod5f", 16'h9610, {product_high, product_low});
    run(16'h0260);
    chk("idx60", 16'h0000, {15'h0000, indexed_mode});
    chk("prod60", 16'h9610, {product_high, product_low});
  endtask : mulreg_scn
  initial
  begin
    repeat (8) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk) #1;
    chk("rstprod", 16'h0000, {product_high, product_low});
    chk("rstacc", 16'h0000, {acc, 7'h00, busy});
    load_scn();
    store_scn();
    mulimm_scn();
    mulreg_scn();
    end_of_test();
  end
endmodule : testbench
`default_nettype wire
